/* File: src/irq_status_cfg.svh */
`ifndef IRQ_STATUS_CFG_SVH
`define IRQ_STATUS_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define OFS_SMODE_PLL_FIFO   12'h01f
`define OFS_SMODE_PATTERN    12'h020
`define OFS_SMODE_PAIR_A     12'h021
`define OFS_PLL_FIFO_STATUS  12'h023
`define OFS_PATTERN_STATUS   12'h024
`define OFS_PAIR_A_STATUS    12'h025
`define OFS_LANE_FULL        12'h30c
`define OFS_LANE_EMPTY       12'h30d

// ****************************************************************
// field positions inside the eight-bit registers
// ****************************************************************
`define BIT_SERDES_PLL_LOCKED  2
`define BIT_LANE_FIFO_ERROR    1
`define BIT_CH3_PATTERN_ERROR  3
`define BIT_CH2_PATTERN_ERROR  2
`define BIT_CH1_PATTERN_ERROR  1
`define BIT_CH0_PATTERN_ERROR  0
`define BIT_PAIR_A_POWER_ERROR 7
`define BIT_PAIR_A_BLANK_DONE  5
`define BIT_PAIR_A_OSC_ALIGN   4

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define RST_REG        8'h00
`define NUM_EVENTS     9
`define DEFAULT_LANES  8

`endif

/* File: src/irq_status_pkg.sv */
package irq_status_pkg;

   typedef logic [11:0] reg_addr_t;
   typedef logic [7:0]  reg_data_t;

   // order of the event sources inside the flat event vector
   typedef enum {
      EV_LANE_FIFO_ERROR,
      EV_SERDES_PLL_LOCKED,
      EV_CH0_PATTERN_ERROR,
      EV_CH1_PATTERN_ERROR,
      EV_CH2_PATTERN_ERROR,
      EV_CH3_PATTERN_ERROR,
      EV_PAIR_A_OSC_ALIGN,
      EV_PAIR_A_BLANK_COMPLETE,
      EV_PAIR_A_POWER_ERROR
   } event_index_e;

endpackage

/* File: src/status_bit_cell.sv */
`timescale 1ns/1ps
`default_nettype none

// one status bit: live view or rising-edge latch, chosen by its mode bit
module status_bit_cell (
   // clock and reset
   input  wire logic CLK,
   input  wire logic RESET,
   // event side
   input  wire logic src,
   input  wire logic sticky_mode_enable,
   input  wire logic clear_pulse,
   // readback side
   output logic      shown,
   output logic      latched
);

   logic prev_q;
   logic prev_d;
   logic latch_q;
   logic latch_d;
   wire  logic rise;

   assign rise   = src & ~prev_q;
   assign prev_d = src;

   // set wins over a clear in the same cycle; leaving sticky mode drops
   // the latch so the interrupt line cannot hang on a bit nobody sees
   always_comb begin
      latch_d = latch_q;
      if (!sticky_mode_enable) begin
         latch_d = 1'b0;
      end else if (rise) begin
         latch_d = 1'b1;
      end else if (clear_pulse) begin
         latch_d = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         prev_q  <= 1'b0;
         latch_q <= 1'b0;
      end else begin
         prev_q  <= prev_d;
         latch_q <= latch_d;
      end
   end

   // live status in plain mode, held capture in sticky mode
   assign shown   = sticky_mode_enable ? latch_q : src;
   assign latched = latch_q;

endmodule

`default_nettype wire

/* File: src/irq_event_status_latch.sv */
`timescale 1ns/1ps
`default_nettype none

`include "irq_status_cfg.svh"

// Functional notes
// - sticky mode set: latch bit on rising edge, hold, pull IRQ_N low.
// - writing one to a latched status bit clears it.
// - bit 2 of the PLL/FIFO status register reads one when PLL locked.
// - bit 1 flags lane FIFO error when any lane FIFO is full or empty.
// - lane FIFO error stays until link is disabled and enabled again.
// - per-lane full at 0x30C, per-lane empty at 0x30D, readable.
// - 0x024 bits 3..0 flag pattern failure on channels 3..0.
// - 0x024 bits 7..4 are reserved and read zero.
// - 0x025 bit 7 flags pair A input over power threshold.
// - 0x025 bit 5 shows pair A output blanking completed.
// - 0x025 bit 4 shows pair A oscillator alignment tripped.
// - mode one latches and interrupts; mode zero shows live status.
module irq_event_status_latch
   import irq_status_pkg::*;
#(
   parameter int LANES = `DEFAULT_LANES
) (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RESET,
   // register port
   input  wire logic [11:0]      ADDR,
   input  wire logic [7:0]       WDATA,
   input  wire logic             WR,
   output logic      [7:0]       RDATA,
   // event sources
   input  wire logic             SERDES_PLL_LOCKED,
   input  wire logic             LINK_ENABLE,
   input  wire logic [LANES-1:0] LANE_FIFO_FULL,
   input  wire logic [LANES-1:0] LANE_FIFO_EMPTY,
   input  wire logic [3:0]       PATTERN_ERROR,
   input  wire logic             PAIR_A_POWER_ERROR,
   input  wire logic             PAIR_A_BLANK_COMPLETE,
   input  wire logic             PAIR_A_OSC_ALIGN,
   // interrupt
   output logic                  IRQ_N
);

   // ****************************************************************
   // parameter check
   // ****************************************************************
   // lane indications are read through one eight-bit register each
   if (LANES < 1 || LANES > 8) begin : g_lanes_check
      $error("LANES must lie between 1 and 8");
   end

   // ****************************************************************
   // declarations
   // ****************************************************************
   reg_data_t                 smode_pll_fifo_q;
   reg_data_t                 smode_pattern_q;
   reg_data_t                 smode_pair_a_q;
   reg_data_t                 smode_pll_fifo_d;
   reg_data_t                 smode_pattern_d;
   reg_data_t                 smode_pair_a_d;
   logic                      fifo_err_q;
   logic                      fifo_err_d;
   reg_data_t                 rdata_q;
   reg_data_t                 rdata_d;
   logic                      irq_n_q;
   logic                      irq_n_d;
   logic [`NUM_EVENTS-1:0]    ev_src;
   logic [`NUM_EVENTS-1:0]    ev_mode;
   logic [`NUM_EVENTS-1:0]    ev_clear;
   logic [`NUM_EVENTS-1:0]    ev_shown;
   logic [`NUM_EVENTS-1:0]    ev_latched;
   wire  logic                wr_smode_pll_fifo;
   wire  logic                wr_smode_pattern;
   wire  logic                wr_smode_pair_a;
   wire  logic                wr_pll_fifo_status;
   wire  logic                wr_pattern_status;
   wire  logic                wr_pair_a_status;
   wire  logic                rd_sel_smode_pll_fifo;
   wire  logic                rd_sel_smode_pattern;
   wire  logic                rd_sel_smode_pair_a;
   wire  logic                rd_sel_pll_fifo;
   wire  logic                rd_sel_pattern;
   wire  logic                rd_sel_pair_a;
   wire  logic                rd_sel_lane_full;
   wire  logic                rd_sel_lane_empty;
   wire  logic                any_lane_fault;
   wire  reg_data_t           lane_full_word;
   wire  reg_data_t           lane_empty_word;
   wire  reg_data_t           pll_fifo_status_word;
   wire  reg_data_t           pattern_status_word;
   wire  reg_data_t           pair_a_status_word;

   // ****************************************************************
   // write decode
   // ****************************************************************
   // a write to a read-only or unmapped address matches no strobe
   assign wr_smode_pll_fifo  = WR && (ADDR == `OFS_SMODE_PLL_FIFO);
   assign wr_smode_pattern   = WR && (ADDR == `OFS_SMODE_PATTERN);
   assign wr_smode_pair_a    = WR && (ADDR == `OFS_SMODE_PAIR_A);
   assign wr_pll_fifo_status = WR && (ADDR == `OFS_PLL_FIFO_STATUS);
   assign wr_pattern_status  = WR && (ADDR == `OFS_PATTERN_STATUS);
   assign wr_pair_a_status   = WR && (ADDR == `OFS_PAIR_A_STATUS);

   // reads need no strobe: the word for ADDR is registered every cycle
   assign rd_sel_smode_pll_fifo = (ADDR == `OFS_SMODE_PLL_FIFO);
   assign rd_sel_smode_pattern  = (ADDR == `OFS_SMODE_PATTERN);
   assign rd_sel_smode_pair_a   = (ADDR == `OFS_SMODE_PAIR_A);
   assign rd_sel_pll_fifo       = (ADDR == `OFS_PLL_FIFO_STATUS);
   assign rd_sel_pattern        = (ADDR == `OFS_PATTERN_STATUS);
   assign rd_sel_pair_a         = (ADDR == `OFS_PAIR_A_STATUS);
   assign rd_sel_lane_full      = (ADDR == `OFS_LANE_FULL);
   assign rd_sel_lane_empty     = (ADDR == `OFS_LANE_EMPTY);

   // ****************************************************************
   // mode registers
   // ****************************************************************
   // all eight bits are kept and read back, reserved ones included
   assign smode_pll_fifo_d = wr_smode_pll_fifo ? WDATA : smode_pll_fifo_q;
   assign smode_pattern_d  = wr_smode_pattern  ? WDATA : smode_pattern_q;
   assign smode_pair_a_d   = wr_smode_pair_a   ? WDATA : smode_pair_a_q;

   always_ff @(posedge CLK) begin
      if (RESET) begin
         smode_pll_fifo_q <= `RST_REG;
         smode_pattern_q  <= `RST_REG;
         smode_pair_a_q   <= `RST_REG;
      end else begin
         smode_pll_fifo_q <= smode_pll_fifo_d;
         smode_pattern_q  <= smode_pattern_d;
         smode_pair_a_q   <= smode_pair_a_d;
      end
   end

   // ****************************************************************
   // lane fifo error
   // ****************************************************************
   // the fault is held in hardware; only dropping the link enable removes
   // it, so software must cycle the link even after a write-one clear
   assign any_lane_fault = |(LANE_FIFO_FULL | LANE_FIFO_EMPTY);

   always_comb begin
      fifo_err_d = fifo_err_q;
      if (!LINK_ENABLE) begin
         fifo_err_d = 1'b0;
      end else if (any_lane_fault) begin
         fifo_err_d = 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (RESET) begin
         fifo_err_q <= 1'b0;
      end else begin
         fifo_err_q <= fifo_err_d;
      end
   end

   // ****************************************************************
   // event mapping
   // ****************************************************************
   // the lane fault reaches its cell through the hold flag, one edge later
   assign ev_src[EV_LANE_FIFO_ERROR]       = fifo_err_q;
   assign ev_src[EV_SERDES_PLL_LOCKED]     = SERDES_PLL_LOCKED;
   assign ev_src[EV_CH0_PATTERN_ERROR]     = PATTERN_ERROR[0];
   assign ev_src[EV_CH1_PATTERN_ERROR]     = PATTERN_ERROR[1];
   assign ev_src[EV_CH2_PATTERN_ERROR]     = PATTERN_ERROR[2];
   assign ev_src[EV_CH3_PATTERN_ERROR]     = PATTERN_ERROR[3];
   assign ev_src[EV_PAIR_A_OSC_ALIGN]      = PAIR_A_OSC_ALIGN;
   assign ev_src[EV_PAIR_A_BLANK_COMPLETE] = PAIR_A_BLANK_COMPLETE;
   assign ev_src[EV_PAIR_A_POWER_ERROR]    = PAIR_A_POWER_ERROR;

   assign ev_mode[EV_LANE_FIFO_ERROR] =
      smode_pll_fifo_q[`BIT_LANE_FIFO_ERROR];
   assign ev_mode[EV_SERDES_PLL_LOCKED] =
      smode_pll_fifo_q[`BIT_SERDES_PLL_LOCKED];
   assign ev_mode[EV_CH0_PATTERN_ERROR] =
      smode_pattern_q[`BIT_CH0_PATTERN_ERROR];
   assign ev_mode[EV_CH1_PATTERN_ERROR] =
      smode_pattern_q[`BIT_CH1_PATTERN_ERROR];
   assign ev_mode[EV_CH2_PATTERN_ERROR] =
      smode_pattern_q[`BIT_CH2_PATTERN_ERROR];
   assign ev_mode[EV_CH3_PATTERN_ERROR] =
      smode_pattern_q[`BIT_CH3_PATTERN_ERROR];
   assign ev_mode[EV_PAIR_A_OSC_ALIGN] =
      smode_pair_a_q[`BIT_PAIR_A_OSC_ALIGN];
   assign ev_mode[EV_PAIR_A_BLANK_COMPLETE] =
      smode_pair_a_q[`BIT_PAIR_A_BLANK_DONE];
   assign ev_mode[EV_PAIR_A_POWER_ERROR] =
      smode_pair_a_q[`BIT_PAIR_A_POWER_ERROR];

   // write one to a status bit clears its latch
   assign ev_clear[EV_LANE_FIFO_ERROR] = wr_pll_fifo_status &
      WDATA[`BIT_LANE_FIFO_ERROR];
   assign ev_clear[EV_SERDES_PLL_LOCKED] = wr_pll_fifo_status &
      WDATA[`BIT_SERDES_PLL_LOCKED];
   assign ev_clear[EV_CH0_PATTERN_ERROR] = wr_pattern_status &
      WDATA[`BIT_CH0_PATTERN_ERROR];
   assign ev_clear[EV_CH1_PATTERN_ERROR] = wr_pattern_status &
      WDATA[`BIT_CH1_PATTERN_ERROR];
   assign ev_clear[EV_CH2_PATTERN_ERROR] = wr_pattern_status &
      WDATA[`BIT_CH2_PATTERN_ERROR];
   assign ev_clear[EV_CH3_PATTERN_ERROR] = wr_pattern_status &
      WDATA[`BIT_CH3_PATTERN_ERROR];
   assign ev_clear[EV_PAIR_A_OSC_ALIGN] = wr_pair_a_status &
      WDATA[`BIT_PAIR_A_OSC_ALIGN];
   assign ev_clear[EV_PAIR_A_BLANK_COMPLETE] = wr_pair_a_status &
      WDATA[`BIT_PAIR_A_BLANK_DONE];
   assign ev_clear[EV_PAIR_A_POWER_ERROR] = wr_pair_a_status &
      WDATA[`BIT_PAIR_A_POWER_ERROR];

   // ****************************************************************
   // status cells
   // ****************************************************************
   // each cell keeps its edge history in plain mode too, so turning a
   // mode bit on while its source is high raises no false capture
   for (genvar i = 0; i < `NUM_EVENTS; i++) begin : g_cell
      status_bit_cell u_cell (
         .CLK                (CLK),
         .RESET              (RESET),
         .src                (ev_src[i]),
         .sticky_mode_enable (ev_mode[i]),
         .clear_pulse        (ev_clear[i]),
         .shown              (ev_shown[i]),
         .latched            (ev_latched[i])
      );
   end

   // ****************************************************************
   // readback words
   // ****************************************************************
   // reserved positions are tied to zero in every status word
   assign pll_fifo_status_word = {
      5'h00,
      ev_shown[EV_SERDES_PLL_LOCKED],
      ev_shown[EV_LANE_FIFO_ERROR],
      1'b0
   };

   assign pattern_status_word = {
      4'h0,
      ev_shown[EV_CH3_PATTERN_ERROR],
      ev_shown[EV_CH2_PATTERN_ERROR],
      ev_shown[EV_CH1_PATTERN_ERROR],
      ev_shown[EV_CH0_PATTERN_ERROR]
   };

   assign pair_a_status_word = {
      ev_shown[EV_PAIR_A_POWER_ERROR],
      1'b0,
      ev_shown[EV_PAIR_A_BLANK_COMPLETE],
      ev_shown[EV_PAIR_A_OSC_ALIGN],
      4'h0
   };

   // unused upper lanes read as zero
   for (genvar l = 0; l < 8; l++) begin : g_lane_bit
      if (l < LANES) begin : g_used
         assign lane_full_word[l]  = LANE_FIFO_FULL[l];
         assign lane_empty_word[l] = LANE_FIFO_EMPTY[l];
      end else begin : g_unused
         assign lane_full_word[l]  = 1'b0;
         assign lane_empty_word[l] = 1'b0;
      end
   end

   // unmapped addresses fall through every select and read zero
   assign rdata_d = ({8{rd_sel_smode_pll_fifo}} & smode_pll_fifo_q)
                  | ({8{rd_sel_smode_pattern}}  & smode_pattern_q)
                  | ({8{rd_sel_smode_pair_a}}   & smode_pair_a_q)
                  | ({8{rd_sel_pll_fifo}}       & pll_fifo_status_word)
                  | ({8{rd_sel_pattern}}        & pattern_status_word)
                  | ({8{rd_sel_pair_a}}         & pair_a_status_word)
                  | ({8{rd_sel_lane_full}}      & lane_full_word)
                  | ({8{rd_sel_lane_empty}}     & lane_empty_word);

   // ****************************************************************
   // interrupt
   // ****************************************************************
   // any held capture keeps the line low; plain-mode bits never reach it;
   // the line is registered so a clear and a new capture never glitch it
   assign irq_n_d = ~(|ev_latched);

   // ****************************************************************
   // output flops
   // ****************************************************************
   // one cycle of latency on both outputs keeps them glitch free
   always_ff @(posedge CLK) begin
      if (RESET) begin
         rdata_q <= `RST_REG;
         irq_n_q <= 1'b1;
      end else begin
         rdata_q <= rdata_d;
         irq_n_q <= irq_n_d;
      end
   end

   assign RDATA = rdata_q;
   assign IRQ_N = irq_n_q;

endmodule

`default_nettype wire

/* File: verification/irq_status_asserts.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// port-level checks
// ****************************************************************
module irq_status_asserts #(
   parameter int LANES = 8
) (
   input wire logic             CLK,
   input wire logic             RESET,
   input wire logic [11:0]      ADDR,
   input wire logic [7:0]       WDATA,
   input wire logic             WR,
   input wire logic [7:0]       RDATA,
   input wire logic             SERDES_PLL_LOCKED,
   input wire logic             LINK_ENABLE,
   input wire logic [LANES-1:0] LANE_FIFO_FULL,
   input wire logic [LANES-1:0] LANE_FIFO_EMPTY,
   input wire logic [3:0]       PATTERN_ERROR,
   input wire logic             PAIR_A_POWER_ERROR,
   input wire logic             PAIR_A_BLANK_COMPLETE,
   input wire logic             PAIR_A_OSC_ALIGN,
   input wire logic             IRQ_N
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);

   chk_reset_quiet:
      assert property (disable iff (1'b0) RESET |=> IRQ_N && RDATA == 8'h00)
      else $error("outputs not quiet in reset");
   chk_reserved_zero:
      assert property ($past(ADDR) == 12'h024 |-> RDATA[7:4] == 4'h0)
      else $error("reserved pattern bits not zero");
   // a fresh rise reads one in either mode, provided nothing is written
   chk_ch3_visible:
      assert property ((!PATTERN_ERROR[3] && !WR) ##1
         (PATTERN_ERROR[3] && !WR && ADDR == 12'h024)[*4] |-> RDATA[3])
      else $error("channel 3 failure not reported");
   chk_pll_visible:
      assert property (!SERDES_PLL_LOCKED ##1
         (SERDES_PLL_LOCKED && ADDR == 12'h023 && !WR)[*4] |-> RDATA[2])
      else $error("pll lock not reported");
   chk_power_visible:
      assert property ($rose(PAIR_A_POWER_ERROR) ##0
         (PAIR_A_POWER_ERROR && !WR && ADDR == 12'h025)[*4] |-> RDATA[7])
      else $error("power error not reported");
   // only a write can release the interrupt: a write-one clear two edges
   // before, or a mode write three edges before
   chk_irq_release:
      assert property ($rose(IRQ_N) |-> $past(WR, 2) || $past(WR, 3))
      else $error("interrupt released without a write");
   chk_lane_full:
      assert property ($past(ADDR) == 12'h30c &&
         $past(LANE_FIFO_FULL) == $past(LANE_FIFO_FULL, 2)
         |-> RDATA == 8'($past(LANE_FIFO_FULL)))
      else $error("lane full word wrong");
   chk_lane_empty:
      assert property ($past(ADDR) == 12'h30d &&
         $past(LANE_FIFO_EMPTY) == $past(LANE_FIFO_EMPTY, 2)
         |-> RDATA == 8'($past(LANE_FIFO_EMPTY)))
      else $error("lane empty word wrong");
endmodule

bind irq_event_status_latch irq_status_asserts #(.LANES(LANES)) u_chk (.*);

`default_nettype wire

/* File: verification/irq_event_status_latch_bench.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("BAD %0t %s", $time, msg); \
   end \
end

module irq_event_status_latch_bench import irq_status_pkg::*;;
   logic       clk = 1'b0;
   logic       reset = 1'b1;
   reg_addr_t  addr = 12'h000;
   reg_data_t  wdata = 8'h00;
   logic       wr = 1'b0;
   reg_data_t  rdata;
   logic       pll = 1'b0;
   logic       link = 1'b0;
   logic [7:0] full = 8'h00;
   logic [7:0] empty = 8'h00;
   logic [3:0] pat = 4'h0;
   logic [2:0] pa = 3'h0;
   logic       irq_n;
   int         n_fail = 0;
   int         cmp_count = 0;

   irq_event_status_latch #(.LANES(8)) dut (
      .CLK                   (clk),
      .RESET                 (reset),
      .ADDR                  (addr),
      .WDATA                 (wdata),
      .WR                    (wr),
      .RDATA                 (rdata),
      .SERDES_PLL_LOCKED     (pll),
      .LINK_ENABLE           (link),
      .LANE_FIFO_FULL        (full),
      .LANE_FIFO_EMPTY       (empty),
      .PATTERN_ERROR         (pat),
      .PAIR_A_POWER_ERROR    (pa[2]),
      .PAIR_A_BLANK_COMPLETE (pa[1]),
      .PAIR_A_OSC_ALIGN      (pa[0]),
      .IRQ_N                 (irq_n)
   );

   // ****************************************************************
   // port tasks
   // ****************************************************************
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic wr_reg(input reg_addr_t a, input reg_data_t d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   // read data is registered, so it is judged one cycle after the address
   task automatic rd_chk(input reg_addr_t a, input reg_data_t e);
      @(negedge clk);
      addr = a;
      @(negedge clk);
      `CHK(rdata, e, "read word")
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      `CHK(irq_n, 1'b1, "irq after reset")
      rd_chk(12'h020, 8'h00);
      rd_chk(12'h024, 8'h00);
   endtask

   task automatic t_plain;
      @(negedge clk);
      addr = 12'h024;
      pat = 4'hf;
      idle(4);
      `CHK(rdata, 8'h0f, "live pattern word")
      `CHK(irq_n, 1'b1, "plain mode irq")
      pat = 4'h0;
      rd_chk(12'h024, 8'h00);
      addr = 12'h023;
      pll = 1'b1;
      idle(4);
      `CHK(rdata[2], 1'b1, "pll lock bit")
      addr = 12'h025;
      pa = 3'h7;
      idle(4);
      `CHK(rdata, 8'hb0, "pair word")
      pa = 3'h0;
   endtask

   task automatic t_sticky;
      wr_reg(12'h020, 8'h0f);
      wr_reg(12'h021, 8'hb0);
      rd_chk(12'h021, 8'hb0);
      pat = 4'h4;
      idle(1);
      pat = 4'h0;
      `CHK(irq_n, 1'b1, "irq too early")
      idle(1);
      `CHK(irq_n, 1'b0, "irq not raised")
      rd_chk(12'h024, 8'h04);
      pa = 3'h4;
      idle(1);
      pa = 3'h0;
      wr_reg(12'h024, 8'h04);
      rd_chk(12'h024, 8'h00);
      `CHK(irq_n, 1'b0, "irq dropped early")
      rd_chk(12'h025, 8'h80);
      wr_reg(12'h025, 8'h80);
      idle(1);
      `CHK(irq_n, 1'b1, "irq not released")
      for (int i = 0; i < 2; i++) begin
         pa = 3'(1 << i);
         idle(1);
         pa = 3'h0;
         rd_chk(12'h025, reg_data_t'(8'h10 << i));
         wr_reg(12'h025, 8'hff);
      end
      wr_reg(12'h020, 8'h00);
      wr_reg(12'h021, 8'h00);
   endtask

   task automatic t_lane;
      wr_reg(12'h01f, 8'h02);
      link = 1'b1;
      full = 8'h10;
      empty = 8'h03;
      rd_chk(12'h30c, 8'h10);
      rd_chk(12'h30d, 8'h03);
      full = 8'h00;
      empty = 8'h00;
      idle(2);
      `CHK(irq_n, 1'b0, "lane error irq")
      rd_chk(12'h023, 8'h06);
      wr_reg(12'h023, 8'h02);
      idle(1);
      `CHK(irq_n, 1'b1, "lane latch clear")
      wr_reg(12'h01f, 8'h00);
      rd_chk(12'h023, 8'h06);
      link = 1'b0;
      idle(2);
      link = 1'b1;
      rd_chk(12'h023, 8'h04);
   endtask

   task automatic t_corner;
      wr_reg(12'h01f, 8'h04);
      pll = 1'b0;
      idle(1);
      pll = 1'b1;
      idle(2);
      `CHK(irq_n, 1'b0, "pll lock irq")
      rd_chk(12'h023, 8'h04);
      wr_reg(12'h023, 8'h04);
      idle(1);
      `CHK(irq_n, 1'b1, "pll latch clear")
      // a clear meeting a new rise in the same cycle loses to the rise
      wr_reg(12'h020, 8'h01);
      @(negedge clk);
      addr = 12'h024;
      wdata = 8'h01;
      wr = 1'b1;
      pat = 4'h1;
      @(negedge clk);
      wr = 1'b0;
      rd_chk(12'h024, 8'h01);
      `CHK(irq_n, 1'b0, "rise lost to clear")
      // dropping the mode bit drops the capture
      wr_reg(12'h020, 8'h00);
      idle(1);
      `CHK(irq_n, 1'b0, "irq dropped too soon")
      idle(1);
      `CHK(irq_n, 1'b1, "mode clear irq")
      rd_chk(12'h024, 8'h01);
      pat = 4'h0;
      wr_reg(12'h024, 8'hff);
      rd_chk(12'h024, 8'h00);
      full = 8'h5a;
      wr_reg(12'h30c, 8'hff);
      rd_chk(12'h30c, 8'h5a);
      full = 8'h00;
      wr_reg(12'h022, 8'hff);
      rd_chk(12'h022, 8'h00);
      // a reset in mid-run drops modes and captures alike
      wr_reg(12'h021, 8'hb0);
      pa = 3'h4;
      idle(1);
      pa = 3'h0;
      idle(1);
      `CHK(irq_n, 1'b0, "power capture irq")
      reset = 1'b1;
      idle(2);
      reset = 1'b0;
      `CHK(irq_n, 1'b1, "irq after mid reset")
      rd_chk(12'h021, 8'h00);
      rd_chk(12'h025, 8'h00);
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      forever #10 clk = ~clk;
   end

   initial begin
      repeat (4) @(negedge clk);
      reset = 1'b0;
      t_reset;
      t_plain;
      t_sticky;
      t_lane;
      t_corner;
      report_and_stop;
   end

   // whole sequence is well under 400 cycles
   initial begin
      #100000;
      n_fail++;
      report_and_stop;
   end
endmodule

`default_nettype wire
